// ==== three_wire_serial_io_pkg.sv ====
// Constants, field layouts and carrier types of the three-wire serial unit.
package three_wire_serial_io_pkg;

  // ****************************************************************
  // Register offsets on the internal bus.
  // ****************************************************************
  localparam logic [15:0] port1_latch_offset = 16'hff01;
  localparam logic [15:0] port1_level_offset = 16'hff02;
  localparam logic [15:0] port1_direction_offset = 16'hff21;
  localparam logic [15:0] serial_mode_control_offset = 16'hff80;
  localparam logic [15:0] clock_config_register_offset = 16'hff81;
  localparam logic [15:0] serial_shift_register_offset = 16'hff82;
  localparam logic [15:0] transmit_buffer_offset = 16'hff83;
  localparam logic [15:0] transfer_status_offset = 16'hff84;

  // ****************************************************************
  // Field positions.
  // ****************************************************************
  localparam int serial_enable_bit_pos = 7;
  localparam int transmit_receive_select_pos = 6;
  localparam int first_bit_order_pos = 4;
  localparam int transfer_active_flag_pos = 0;
  localparam int clock_polarity_select_pos = 4;
  localparam int data_phase_select_pos = 3;
  localparam int clock_rate_select_lsb = 0;
  localparam int transfer_done_irq_flag_pos = 0;
  localparam int clock_pin_bit = 0;
  localparam int input_pin_bit = 1;
  localparam int output_pin_bit = 2;

  // ****************************************************************
  // Reset values and fixed codes.
  // ****************************************************************
  localparam logic [7:0] port1_direction_reset = 8'hff;
  localparam logic [7:0] port1_latch_reset = 8'h00;
  localparam logic [7:0] transmit_buffer_reset = 8'h00;
  localparam logic [2:0] slave_clock_code = 3'h7;
  localparam logic [2:0] last_bit_index = 3'h7;
  localparam logic [3:0] frame_pulses = 4'h8;

  // Software-written mode bits; the active flag lives apart.
  typedef struct packed {
    logic serial_enable_bit;
    logic transmit_receive_select;
    logic first_bit_order;
  } mode_type;

  // Clock configuration fields.
  typedef struct packed {
    logic clock_polarity_select;
    logic data_phase_select;
    logic [2:0] clock_rate_select;
  } clock_config_type;

  // Drive of one two-way pin.
  typedef struct packed {
    logic out;
    logic oe;
  } pin_drive_type;

endpackage : three_wire_serial_io_pkg

// ==== clock_rate_divider.sv ====
// Half-period tick generator for the master serial clock.
module clock_rate_divider (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic reset,
  // Control.
  input wire logic run,
  input wire logic [2:0] rate_sel,
  // Tick, one cycle, once per half serial clock period.
  output logic tick
);

  // ****************************************************************
  // Counter.
  // ****************************************************************
  // Half period is 2^code core cycles, so a full period is 2^(code+1).
  logic [6:0] cnt_q;
  logic [6:0] cnt_d;
  wire logic [6:0] limit_w;

  assign limit_w = 7'((7'h01 << rate_sel) - 7'h01);
  assign tick = run && (cnt_q == limit_w);
  // Restart on every tick and while stopped so the first half period
  // of a frame is full length.
  assign cnt_d = (!run || tick) ? 7'h00 : 7'(cnt_q + 7'h01);

  // Counter register.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      cnt_q <= 7'h00;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // The counter climbs one step a cycle while running between ticks.
  a_divider_climb: assert property (@(posedge core_clk) disable iff (reset)
    run && !tick && $stable(rate_sel) |=> !run || cnt_q == 7'($past(cnt_q) + 7'h01))
    else $error("divider counter did not advance");

endmodule : clock_rate_divider

// ==== three_wire_serial_io.sv ====
// Three-wire clocked serial unit with its port 1 pin control.
module three_wire_serial_io (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic reset,
  // Register port.
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  // Serial clock pin.
  input wire logic serial_clock_pin_in,
  output logic serial_clock_pin_out,
  output logic serial_clock_pin_oe,
  // Serial input pin.
  input wire logic serial_in_pin_in,
  output logic serial_in_pin_out,
  output logic serial_in_pin_oe,
  // Serial output pin.
  input wire logic serial_out_pin_in,
  output logic serial_out_pin_out,
  output logic serial_out_pin_oe,
  // Status.
  output logic transfer_done_irq_flag,
  output logic transfer_active_flag
);

  // ****************************************************************
  // Register state.
  // ****************************************************************
  logic [7:0] dir_q; // Port 1 direction bits.
  logic [7:0] latch_q; // Port 1 output latches.
  three_wire_serial_io_pkg::mode_type mode_q; // Enable, mode and order.
  three_wire_serial_io_pkg::clock_config_type cfg_q; // Clock setup.
  logic [7:0] tx_q; // Transmit buffer.
  logic [7:0] shift_q; // Serial shift register.
  logic [7:0] shift_d;
  logic active_q; // Transfer in progress.
  logic active_d;
  logic done_q; // Sticky completion flag.
  logic done_d;
  logic [7:0] rdata_d;

  // ****************************************************************
  // Frame state.
  // ****************************************************************
  logic sck_q; // Master serial clock level.
  logic sck_d;
  logic clk_prev_q; // Last sampled clock pin level, for slave edges.
  logic [2:0] bit_cnt_q; // Bits finished in this frame.
  logic [2:0] bit_cnt_d;
  logic so_q; // Serial data output.
  logic so_d;
  logic sample_q; // Input bit caught at the leading edge.
  logic sample_d;
  three_wire_serial_io_pkg::pin_drive_type clk_pin_d;
  three_wire_serial_io_pkg::pin_drive_type in_pin_d;
  three_wire_serial_io_pkg::pin_drive_type out_pin_d;

  // ****************************************************************
  // Address decode.
  // ****************************************************************
  wire logic hit_dir_w;
  wire logic hit_latch_w;
  wire logic hit_level_w;
  wire logic hit_mode_w;
  wire logic hit_cfg_w;
  wire logic hit_shift_w;
  wire logic hit_tx_w;
  wire logic hit_status_w;

  assign hit_dir_w =
    reg_addr == three_wire_serial_io_pkg::port1_direction_offset;
  assign hit_latch_w =
    reg_addr == three_wire_serial_io_pkg::port1_latch_offset;
  assign hit_level_w =
    reg_addr == three_wire_serial_io_pkg::port1_level_offset;
  assign hit_mode_w =
    reg_addr == three_wire_serial_io_pkg::serial_mode_control_offset;
  assign hit_cfg_w =
    reg_addr == three_wire_serial_io_pkg::clock_config_register_offset;
  assign hit_shift_w =
    reg_addr == three_wire_serial_io_pkg::serial_shift_register_offset;
  assign hit_tx_w =
    reg_addr == three_wire_serial_io_pkg::transmit_buffer_offset;
  assign hit_status_w =
    reg_addr == three_wire_serial_io_pkg::transfer_status_offset;

  // ****************************************************************
  // Mode decode and transfer start.
  // ****************************************************************
  wire logic en_w;
  wire logic trmd_w;
  wire logic lsb_first_w;
  wire logic master_w;
  wire logic idle_w;
  wire logic start_tx_w;
  wire logic start_rx_w;
  wire logic start_w;

  assign en_w = mode_q.serial_enable_bit;
  assign trmd_w = mode_q.transmit_receive_select;
  assign lsb_first_w = mode_q.first_bit_order;
  // Rate code all ones hands the clock to the far end.
  assign master_w = cfg_q.clock_rate_select !=
    three_wire_serial_io_pkg::slave_clock_code;
  // Polarity zero idles the clock high, polarity one idles it low.
  assign idle_w = !cfg_q.clock_polarity_select;
  // A start while a frame runs is ignored; software must not do it.
  assign start_tx_w = reg_write && hit_tx_w && en_w && trmd_w &&
    !active_q;
  assign start_rx_w = reg_read && hit_shift_w && en_w && !trmd_w &&
    !active_q;
  assign start_w = start_tx_w || start_rx_w;

  // ****************************************************************
  // Serial clock edges.
  // ****************************************************************
  wire logic tick_w;
  wire logic lead_w;
  wire logic trail_w;
  wire logic done_evt_w;
  wire logic sin_w;
  wire logic [7:0] shifted_w;
  wire logic out_bit_w;
  wire logic next_bit_w;
  wire logic first_bit_w;

  // The divider only runs inside a master frame.
  clock_rate_divider rate_div (
    .core_clk(core_clk),
    .reset(reset),
    .run(active_q && master_w),
    .rate_sel(cfg_q.clock_rate_select),
    .tick(tick_w)
  );

  // Leading edge leaves the idle level, trailing edge returns to it.
  // Slave edges come from the pin, which is already in this clock domain.
  assign lead_w = active_q && (master_w ? (tick_w && sck_q == idle_w) :
    (clk_prev_q == idle_w && serial_clock_pin_in != idle_w));
  assign trail_w = active_q && (master_w ? (tick_w && sck_q != idle_w) :
    (clk_prev_q != idle_w && serial_clock_pin_in == idle_w));
  // The eighth trailing edge closes the frame.
  assign done_evt_w = trail_w &&
    bit_cnt_q == three_wire_serial_io_pkg::last_bit_index;

  // Phase zero samples at the trailing edge, phase one at the leading.
  assign sin_w = cfg_q.data_phase_select ? sample_q :
    serial_in_pin_in;
  assign shifted_w = lsb_first_w ? {sin_w, shift_q[7:1]} :
    {shift_q[6:0], sin_w};
  assign out_bit_w = lsb_first_w ? shift_q[0] : shift_q[7];
  assign next_bit_w = lsb_first_w ? shifted_w[0] : shifted_w[7];
  assign first_bit_w = lsb_first_w ? reg_wdata[0] : reg_wdata[7];

  // ****************************************************************
  // Next-state logic.
  // ****************************************************************
  // Active flag, shift register and bit counter. Enable low clears
  // them on the next edge; there is no asynchronous path in this
  // design, so a clear lands one cycle after the write.
  always_comb begin
    active_d = active_q;
    shift_d = shift_q;
    bit_cnt_d = bit_cnt_q;
    if (!en_w) begin
      active_d = 1'b0;
      shift_d = 8'h00;
      bit_cnt_d = 3'h0;
    end else if (start_w) begin
      active_d = 1'b1;
      bit_cnt_d = 3'h0;
      if (start_tx_w) begin
        shift_d = reg_wdata;
      end
    end else if (trail_w) begin
      shift_d = shifted_w;
      bit_cnt_d = 3'(bit_cnt_q + 3'h1);
      if (done_evt_w) begin
        active_d = 1'b0;
      end
    end
  end

  // Master clock: toggles on each tick, parks at idle between frames.
  // A stop in mid-frame parks it at once, so no half pulse is left.
  assign sck_d = (!active_q || !en_w) ? idle_w :
    (tick_w ? !sck_q : sck_q);

  // Input sample for phase one, caught at the leading edge.
  assign sample_d = lead_w ? serial_in_pin_in : sample_q;

  // Serial data output. Receive-only and stop hold it low. Phase one
  // shows the first bit at the start, phase zero at the leading edge.
  always_comb begin
    so_d = so_q;
    if (!en_w || !trmd_w) begin
      so_d = 1'b0;
    end else if (start_tx_w && cfg_q.data_phase_select) begin
      so_d = first_bit_w;
    end else if (lead_w && !cfg_q.data_phase_select) begin
      so_d = out_bit_w;
    end else if (trail_w && cfg_q.data_phase_select && !done_evt_w) begin
      so_d = next_bit_w;
    end
  end

  // Completion flag: hardware set wins over a software clear.
  assign done_d = done_evt_w || (done_q && !(reg_write && hit_status_w &&
    !reg_wdata[three_wire_serial_io_pkg::transfer_done_irq_flag_pos]));

  // ****************************************************************
  // Pin routing.
  // ****************************************************************
  // Each direction bit opens or closes its output buffer. The serial
  // unit only takes a pin's value over while it is enabled and the
  // pin carries a serial signal in this mode.
  always_comb begin
    clk_pin_d.oe = !dir_q[three_wire_serial_io_pkg::clock_pin_bit];
    in_pin_d.oe = !dir_q[three_wire_serial_io_pkg::input_pin_bit];
    out_pin_d.oe = !dir_q[three_wire_serial_io_pkg::output_pin_bit];
    in_pin_d.out = latch_q[three_wire_serial_io_pkg::input_pin_bit];
    if (en_w && master_w) begin
      clk_pin_d.out = sck_q;
    end else begin
      clk_pin_d.out = latch_q[three_wire_serial_io_pkg::clock_pin_bit];
    end
    if (en_w && trmd_w) begin
      out_pin_d.out = so_q;
    end else begin
      out_pin_d.out = latch_q[three_wire_serial_io_pkg::output_pin_bit];
    end
  end

  // ****************************************************************
  // Read data.
  // ****************************************************************
  // A read with no strobe or at an unmapped address returns zero.
  always_comb begin
    rdata_d = 8'h00;
    if (!reg_read) begin
      rdata_d = 8'h00;
    end else if (hit_dir_w) begin
      rdata_d = dir_q;
    end else if (hit_latch_w) begin
      rdata_d = latch_q;
    end else if (hit_level_w) begin
      rdata_d = {5'h00, serial_out_pin_in, serial_in_pin_in,
        serial_clock_pin_in};
    end else if (hit_mode_w) begin
      rdata_d = {en_w, trmd_w, 1'b0, lsb_first_w, 3'h0, active_q};
    end else if (hit_cfg_w) begin
      rdata_d = {3'h0, cfg_q};
    end else if (hit_shift_w) begin
      rdata_d = shift_q;
    end else if (hit_tx_w) begin
      rdata_d = tx_q;
    end else if (hit_status_w) begin
      rdata_d = {7'h00, done_q};
    end
  end

  // ****************************************************************
  // Registers written by software.
  // ****************************************************************
  // Configuration takes writes whenever they come; keeping it steady
  // during operation is the software's side of the bargain.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      dir_q <= three_wire_serial_io_pkg::port1_direction_reset;
      latch_q <= three_wire_serial_io_pkg::port1_latch_reset;
      mode_q <= '0;
      cfg_q <= '0;
      tx_q <= three_wire_serial_io_pkg::transmit_buffer_reset;
    end else if (reg_write) begin
      if (hit_dir_w) begin
        dir_q <= reg_wdata;
      end
      if (hit_latch_w) begin
        latch_q <= reg_wdata;
      end
      if (hit_mode_w) begin
        mode_q <= {reg_wdata[three_wire_serial_io_pkg::serial_enable_bit_pos],
          reg_wdata[three_wire_serial_io_pkg::transmit_receive_select_pos],
          reg_wdata[three_wire_serial_io_pkg::first_bit_order_pos]};
      end
      if (hit_cfg_w) begin
        cfg_q <= reg_wdata[4:0];
      end
      if (hit_tx_w) begin
        tx_q <= reg_wdata;
      end
    end
  end

  // ****************************************************************
  // Frame and output registers.
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (reset) begin
      active_q <= 1'b0;
      shift_q <= 8'h00;
      bit_cnt_q <= 3'h0;
      done_q <= 1'b0;
      sck_q <= 1'b1;
      clk_prev_q <= 1'b1;
      so_q <= 1'b0;
      sample_q <= 1'b0;
    end else begin
      active_q <= active_d;
      shift_q <= shift_d;
      bit_cnt_q <= bit_cnt_d;
      done_q <= done_d;
      sck_q <= sck_d;
      clk_prev_q <= serial_clock_pin_in;
      so_q <= so_d;
      sample_q <= sample_d;
    end
  end

  // Every top-level output comes from its own flip-flop.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      reg_rdata <= 8'h00;
      serial_clock_pin_out <= 1'b0;
      serial_clock_pin_oe <= 1'b0;
      serial_in_pin_out <= 1'b0;
      serial_in_pin_oe <= 1'b0;
      serial_out_pin_out <= 1'b0;
      serial_out_pin_oe <= 1'b0;
      transfer_done_irq_flag <= 1'b0;
      transfer_active_flag <= 1'b0;
    end else begin
      reg_rdata <= rdata_d;
      serial_clock_pin_out <= clk_pin_d.out;
      serial_clock_pin_oe <= clk_pin_d.oe;
      serial_in_pin_out <= in_pin_d.out;
      serial_in_pin_oe <= in_pin_d.oe;
      serial_out_pin_out <= out_pin_d.out;
      serial_out_pin_oe <= out_pin_d.oe;
      transfer_done_irq_flag <= done_d;
      transfer_active_flag <= active_d;
    end
  end

  // ****************************************************************
  // Checks.
  // ****************************************************************
  default clocking chk @(posedge core_clk);
  endclocking
  default disable iff (reset);

  // Leading edges seen in the current frame.
  logic [3:0] lead_cnt_q;
  always_ff @(posedge core_clk) begin
    if (reset || start_w) begin
      lead_cnt_q <= 4'h0;
    end else if (lead_w) begin
      lead_cnt_q <= 4'(lead_cnt_q + 4'h1);
    end
  end

  sequence seq_tx_request;
    reg_write && hit_tx_w && en_w && trmd_w && !active_q;
  endsequence

  sequence seq_frame_close;
    done_evt_w ##1 (done_q && !active_q);
  endsequence

  a_reset_phase_type: assert property ($fell(reset) |-> cfg_q == '0)
    else $error("phase type after reset is not type 1");
  a_pin_buffer_dir: assert property (
    serial_out_pin_oe == !$past(dir_q[2]) &&
    serial_clock_pin_oe == !$past(dir_q[0]))
    else $error("output buffer does not follow direction bit");
  a_stop_port_pins: assert property (!en_w |=>
    serial_out_pin_out == $past(latch_q[2]) &&
    serial_clock_pin_out == $past(latch_q[0]))
    else $error("stop mode pins do not show the latches");
  a_stop_clears_frame: assert property (!en_w |=>
    !active_q && shift_q == 8'h00 ##1 !transfer_active_flag || en_w)
    else $error("stop mode did not clear the frame state");
  a_tx_start_active: assert property (seq_tx_request |=>
    active_q && shift_q == $past(reg_wdata) ##1 transfer_active_flag)
    else $error("transmit buffer write did not start a frame");
  a_rx_start_active: assert property (
    reg_read && hit_shift_w && en_w && !trmd_w && !active_q |=>
    active_q && bit_cnt_q == 3'h0)
    else $error("shift register read did not start reception");
  a_frame_done_flag: assert property (done_evt_w |-> seq_frame_close)
    else $error("frame end did not raise done and drop active");
  a_eight_clock_pulses: assert property (done_evt_w && master_w |->
    lead_cnt_q == three_wire_serial_io_pkg::frame_pulses)
    else $error("master frame did not carry eight clock pulses");
  a_clock_parks_idle: assert property (
    !active_q && $stable(cfg_q.clock_polarity_select) |-> sck_q == idle_w)
    else $error("serial clock not at its idle level between frames");
  a_receive_only_low: assert property (!trmd_w |=> !so_q ##1 1'b1)
    else $error("serial data output not low in receive-only mode");

endmodule : three_wire_serial_io

// ==== serial_peer_model.sv ====
// Behavioural peripheral on the far side of the three-wire link.
module serial_peer_model (
  // Clock.
  input wire logic core_clk,
  // Link pins, clock polarity and data phase.
  input wire logic sck,
  input wire logic sdo,
  input wire logic ckp,
  input wire logic dap,
  output logic sdi,
  // Frame control and capture.
  input wire logic load,
  input wire logic [7:0] byte_in,
  output logic [7:0] rx_q,
  output logic [3:0] edges_q
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] tx_q;
  logic sck_q;
  initial sdi = 1'b0;
  // Edges are seen by sampling the pin, so slow rates are needed. The
  // first bit stands from the load on, the others follow trailing edges.
  always @(posedge core_clk) begin
    sck_q <= sck;
    if (load) begin
      tx_q <= {byte_in[6:0], 1'b0};
      rx_q <= 8'h00;
      edges_q <= 4'h0;
      sdi <= byte_in[7];
    end else if (sck != sck_q) begin
      // Phase zero captures at the trailing edge, phase one at the leading.
      if (sck == (ckp ~^ dap)) begin
        rx_q <= {rx_q[6:0], sdo};
        edges_q <= edges_q + 4'h1;
      end
      if (sck == ~ckp) begin
        sdi <= tx_q[7];
        tx_q <= {tx_q[6:0], 1'b0};
      end
    end
  end
endmodule : serial_peer_model

// ==== three_wire_serial_io_tb_top.sv ====
// Self-checking bench for the three-wire serial unit.
module three_wire_serial_io_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [15:0] dir_a = three_wire_serial_io_pkg::port1_direction_offset;
  localparam logic [15:0] lat_a = three_wire_serial_io_pkg::port1_latch_offset;
  localparam logic [15:0] mod_a = three_wire_serial_io_pkg::serial_mode_control_offset;
  localparam logic [15:0] cfg_a = three_wire_serial_io_pkg::clock_config_register_offset;
  localparam logic [15:0] sh_a = three_wire_serial_io_pkg::serial_shift_register_offset;
  localparam logic [15:0] tx_a = three_wire_serial_io_pkg::transmit_buffer_offset;
  localparam logic [15:0] st_a = three_wire_serial_io_pkg::transfer_status_offset;
  logic core_clk, reset, reg_write, reg_read, load, ckp, dap, ext_sck;
  logic [15:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, byte_in, rx_q, t, pb;
  logic [3:0] edges_q;
  logic sck_o, sck_oe, si_o, si_oe, so_o, so_oe, sdi, done, act;
  wire logic sck_w = sck_oe ? sck_o : ext_sck;
  wire logic so_w = so_oe ? so_o : 1'b1;
  wire logic si_w = si_oe ? si_o : sdi;
  int errors, n_checks, cyc, i, k;
  three_wire_serial_io uut (.core_clk(core_clk), .reset(reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata),
    .serial_clock_pin_in(sck_w), .serial_clock_pin_out(sck_o),
    .serial_clock_pin_oe(sck_oe), .serial_in_pin_in(si_w),
    .serial_in_pin_out(si_o), .serial_in_pin_oe(si_oe),
    .serial_out_pin_in(so_w), .serial_out_pin_out(so_o),
    .serial_out_pin_oe(so_oe), .transfer_done_irq_flag(done),
    .transfer_active_flag(act));
  serial_peer_model peer (.core_clk(core_clk), .sck(sck_w), .sdo(so_w),
    .ckp(ckp), .dap(dap), .sdi(sdi), .load(load), .byte_in(byte_in),
    .rx_q(rx_q),
    .edges_q(edges_q));
  // ****************************************************************
  // Clock, timeout and shared tasks.
  // ****************************************************************
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // A hung wait ends here as a mismatch.
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      summarize();
    end
  end
  task automatic chk(input string nm, input logic [7:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_write <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe.
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_read <= 1'b0;
    #1 chk("rdata", reg_rdata, exp);
  endtask : rd
  task automatic start_peer(input logic [7:0] b);
    @(posedge core_clk);
    load <= 1'b1;
    byte_in <= b;
    @(posedge core_clk);
    load <= 1'b0;
  endtask : start_peer
  task automatic wait_done;
    for (i = 0; i < 600 && done !== 1'b1; i++) @(posedge core_clk);
    repeat (4) @(posedge core_clk);
    #1 chk("active", act, 8'h00);
  endtask : wait_done
  function automatic logic [7:0] rev(input logic [7:0] v);
    for (int j = 0; j < 8; j++) rev[j] = v[7-j];
  endfunction : rev
  task automatic summarize;
    if (errors == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize
  // ****************************************************************
  // Main sequence.
  // ****************************************************************
  initial begin
    {reset, reg_write, reg_read, load, ckp, dap, ext_sck} = 7'b1000001;
    {reg_addr, reg_wdata, byte_in} = 32'h0;
    repeat (5) @(posedge core_clk);
    reset <= 1'b0;
    rd(dir_a, 8'hff);
    rd(cfg_a, 8'h00);
    rd(16'hff90, 8'h00);
    wr(dir_a, 8'hfa);
    wr(lat_a, 8'h01);
    repeat (2) @(posedge core_clk);
    #1 chk("sck_oe", {sck_oe, si_oe, so_oe}, 8'h05);
    // Types 1 to 4, both bit orders, two master rates.
    for (k = 0; k < 8; k++) begin
      t = 8'ha5 ^ k[7:0];
      pb = 8'h3c + k[7:0];
      wr(mod_a, 8'h00);
      ckp <= k[1];
      dap <= k[2];
      wr(cfg_a, {3'h0, k[1], k[2], 1'b0, 1'b1, k[0]});
      wr(mod_a, {3'h2, k[0], 4'h0});
      wr(mod_a, {3'h6, k[0], 4'h0});
      start_peer(pb);
      wr(tx_a, t);
      repeat (2) @(posedge core_clk);
      #1 chk("active", act, 8'h01);
      wait_done();
      chk("peer_rx", rx_q, k[0] ? rev(t) : t);
      chk("pulses", edges_q, 8'h08);
      chk("sck_idle", sck_o, {7'h00, !k[1]});
      rd(sh_a, k[0] ? rev(pb) : pb);
      wr(st_a, 8'h00);
      #1 chk("done", done, 8'h00);
    end
    // Receive only: a shift register read starts the frame.
    wr(mod_a, 8'h00);
    ckp <= 1'b0;
    dap <= 1'b0;
    wr(cfg_a, 8'h02);
    wr(mod_a, 8'h80);
    start_peer(8'h96);
    rd(sh_a, 8'h00);
    wait_done();
    chk("so_low", rx_q, 8'h00);
    rd(sh_a, 8'h96);
    // That read starts the next reception; let it finish untouched.
    chk("rx_again", act, 8'h01);
    repeat (80) @(posedge core_clk);
    wr(st_a, 8'h00);
    // Stop in mid-frame clears the internal state.
    wr(mod_a, 8'hc0);
    start_peer(8'h5a);
    wr(tx_a, 8'hff);
    repeat (10) @(posedge core_clk);
    wr(mod_a, 8'h00);
    repeat (2) @(posedge core_clk);
    #1 chk("stop_act", act, 8'h00);
    chk("port_pins", {sck_o, so_o}, 8'h02);
    rd(sh_a, 8'h00);
    rd(mod_a, 8'h00);
    // Slave transfer on a clock that the far side drives into the pin.
    wr(dir_a, 8'hfb);
    wr(cfg_a, 8'h07);
    wr(mod_a, 8'hc0);
    start_peer(8'h69);
    wr(tx_a, 8'h4b);
    repeat (16) begin
      repeat (4) @(posedge core_clk);
      ext_sck <= ~ext_sck;
    end
    wait_done();
    chk("slave_rx", rx_q, 8'h4b);
    rd(sh_a, 8'h69);
    summarize();
  end
endmodule : three_wire_serial_io_tb_top
